// File: tb/first_order_recursive_lowpass_bench.sv
`include "lpf_consts.svh"
module first_order_recursive_lowpass_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SPACING = `LPF_SAMPLE_CYCLES + 1;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic adc_valid, adc_ready, dac_valid, dac_ready;
    logic [7:0] adc_data, dac_data;
    int mismatches = 0;
    int samples_checked = 0;
    int cyc = 0;
    int last, n;
    logic [31:0] seed = 32'h960C70A0;
    logic [7:0] prev = 8'h00;
    logic [7:0] exp_q[$];

    always #20 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) cyc <= cyc + 1;

    first_order_recursive_lowpass u_first_order_recursive_lowpass (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .adc_valid_i(adc_valid), .adc_data_i(adc_data), .adc_ready_o(adc_ready),
        .dac_valid_o(dac_valid), .dac_data_o(dac_data), .dac_ready_i(dac_ready));
    lpf_converters u_lpf_converters (.clk_i(ref_clk_i), .stall_i(stall), .slow_i(slow),
        .adc_valid_o(adc_valid), .adc_data_o(adc_data), .adc_ready_i(adc_ready),
        .dac_valid_i(dac_valid), .dac_data_i(dac_data), .dac_ready_o(dac_ready));

    function automatic logic [31:0] xorshift(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xorshift
    // saturating k*in + m*prev, upper byte kept
    function automatic logic [7:0] filt(input logic [7:0] x, input logic [7:0] p);
        logic [16:0] acc;
        acc = `LPF_COEF_K * {9'h000, x} + `LPF_COEF_M * {9'h000, p};
        if (acc[16])
            acc = 17'h0FFFF;
        return acc[15:8];
    endfunction : filt

    task automatic wrap_up();
        $display("checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task automatic check_word(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : check_word
    task automatic check_int(input int got, input int exp, input string what);
        samples_checked++;
        if (got != exp)
        begin
            mismatches++;
            $display("MISMATCH %0t %s got %0d want %0d", $time, what, got, exp);
        end
    endtask : check_int
    task automatic offer(input logic [7:0] x, input int bound, input bit want);
        bit ok;
        u_lpf_converters.send(x, bound, ok);
        check_int(ok, want, "sample take");
        if (ok)
        begin
            prev = filt(x, prev);
            exp_q.push_back(prev);
        end
        else if (want)
            wrap_up();
    endtask : offer
    task automatic drain();
        n = 0;
        while (u_lpf_converters.got.size() < exp_q.size() && n < 5000)
        begin
            @(posedge ref_clk_i);
            n++;
        end
        if (n >= 5000)
        begin
            check_int(n, 0, "drain wait");
            wrap_up();
        end
    endtask : drain

    initial
    begin
        repeat (6) @(posedge ref_clk_i);
        #1 resetn_i = 1'b1;
        check_word({6'h00, adc_ready, dac_valid}, 8'h00, "flags after reset");
        check_word(dac_data, `LPF_PREV_RESET, "data after reset");
        @(posedge ref_clk_i);
        #1;
        // idle timer starts at zero, so ready comes up at the first edge out of reset
        check_word({7'h00, adc_ready}, 8'h01, "ready after release");
        // ****************************************
        // full-scale step from a cleared delay cell
        // ****************************************
        for (int i = 0; i < 10; i++)
        begin
            offer(8'hFF, 4000, 1'b1);
            check_word({7'h00, adc_ready}, 8'h00, "ready after take");
            if (i > 0)
                check_int(cyc - last, SPACING, "sample spacing");
            last = cyc;
            if (i == 0)
            begin
                n = 0;
                while (dac_valid !== 1'b1 && n < 20)
                begin
                    @(posedge ref_clk_i);
                    #1;
                    n++;
                end
                // two passes with idle steps cannot finish sooner
                check_int(int'(n >= 9 && n <= 11), 1, "result latency");
            end
        end
        // ****************************************
        // random samples, slow sink, then one zero sample
        // ****************************************
        slow = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            seed = xorshift(seed);
            offer(seed[7:0], 4000, 1'b1);
        end
        offer(8'h00, 4000, 1'b1);
        drain();
        // ****************************************
        // stalled sink fills the buffer
        // ****************************************
        stall = 1'b1;
        slow = 1'b0;
        // eight stored words, one in the output stage, one parked in the store step
        for (int i = 0; i < 10; i++)
        begin
            seed = xorshift(seed);
            offer(seed[7:0], 4000, 1'b1);
        end
        seed = xorshift(seed);
        offer(seed[7:0], 2 * SPACING, 1'b0);
        stall = 1'b0;
        offer(seed[7:0], 4000, 1'b1);
        drain();
        check_int(u_lpf_converters.got.size(), exp_q.size(), "output count");
        foreach (exp_q[i])
            check_word(u_lpf_converters.got[i], exp_q[i], "output sample");
        wrap_up();
    end
endmodule : first_order_recursive_lowpass_bench

// File: tb/lpf_converters.sv
// ****************************************
// converter pair facing the filter
// ****************************************
module lpf_converters (
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic slow_i,
    output logic adc_valid_o,
    output logic [7:0] adc_data_o,
    input wire logic adc_ready_i,
    input wire logic dac_valid_i,
    input wire logic [7:0] dac_data_i,
    output logic dac_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    logic phase = 1'b0;
    initial
    begin
        adc_valid_o = 1'b0;
        adc_data_o = 8'hA5;
        dac_ready_o = 1'b0;
    end
    task automatic send(input logic [7:0] s, input int bound, output bit ok);
        int n;
        ok = 1'b0;
        n = 0;
        // let an edge pass so valid is never dropped and raised in one step
        @(posedge clk_i);
        #1;
        adc_valid_o = 1'b1;
        adc_data_o = s;
        while (!ok && n < bound)
        begin
            @(posedge clk_i);
            n++;
            ok = (adc_ready_i === 1'b1);
        end
        #1;
        adc_valid_o = 1'b0;
        // released data line shows no stale value
        adc_data_o = ~s;
    endtask : send
    always @(posedge clk_i)
    begin
        if (dac_valid_i === 1'b1 && dac_ready_o === 1'b1)
            got.push_back(dac_data_i);
        phase = ~phase;
        #1 dac_ready_o = ~stall_i & (~slow_i | phase);
    end
endmodule : lpf_converters

// File: verilog/first_order_recursive_lowpass.sv
`include "lpf_consts.svh"

// ****************************************
// output buffer
// ****************************************
// depth must be a power of two: pointers wrap by overflow
module stream_fifo #(
    parameter int WIDTH = `LPF_FIFO_WIDTH,
    parameter int DEPTH = `LPF_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid_i && in_ready_o;
    // output register refills whenever a word is stored and the register is empty or being drained
    assign pop = (count != '0) && (!out_valid_o || out_ready_i);

    always_comb
    begin
        next_count = count;
        if (push && !pop)
        begin
            next_count = count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_o <= 1'b1;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready_o <= (next_count != (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end
        else if (pop)
        begin
            out_valid_o <= 1'b1;
            out_data_o <= mem[rd_ptr];
        end
        else if (out_ready_i)
        begin
            out_valid_o <= 1'b0;
        end
    end

    a_fifo_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (count <= (AW+1)'(DEPTH)) && ((count == (AW+1)'(DEPTH)) == !in_ready_o))
        else $error("fifo count out of range or ready wrong");

endmodule : stream_fifo

// ****************************************
// recursive low-pass filter
// ****************************************
module first_order_recursive_lowpass (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic adc_valid_i,
    input wire logic [7:0] adc_data_i,
    output logic adc_ready_o,
    output logic dac_valid_o,
    output logic [7:0] dac_data_o,
    input wire logic dac_ready_i
);
    import lpf_pkg::*;

    lpf_state_t state;
    mac_op_t op;
    logic [15:0] acc;
    logic [7:0] sample;
    logic [7:0] prev_out;
    logic [7:0] result;
    logic [10:0] timer;
    logic take;
    logic push;
    logic fifo_ready;

    // fractions times fractions: 16-bit product, saturating accumulate
    function automatic logic [15:0] mac_step(input logic [15:0] acc_in, input mac_op_t cmd_op);
        logic [15:0] prod;
        logic [16:0] sum;
        prod = cmd_op.x * cmd_op.z;
        sum = {1'b0, acc_in} + {1'b0, prod};
        if (!cmd_op.cmd[`LPF_CMD_ACC_BIT])
        begin
            return prod;
        end
        return sum[16] ? 16'hFFFF : sum[15:0];
    endfunction : mac_step

    function automatic logic [7:0] filter_ref(input logic [7:0] s, input logic [7:0] p);
        logic [15:0] a;
        a = mac_step(16'h0000, '{cmd: `LPF_CMD_CLEAR_MUL, x: s, z: `LPF_COEF_K});
        a = mac_step(a, '{cmd: `LPF_CMD_MUL_ADD, x: p, z: `LPF_COEF_M});
        return a[15:8];
    endfunction : filter_ref

    assign take = adc_ready_o && adc_valid_i;
    assign push = (state == ST_STORE) && fifo_ready;

    // ****************************************
    // sample period
    // ****************************************
    // [RULE_09] fixed loop period
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            timer <= '0;
        end
        else if (take)
        begin
            timer <= 11'(`LPF_SAMPLE_CYCLES - 1);
        end
        else if (timer != '0)
        begin
            timer <= timer - 1'b1;
        end
    end

    // ready rises a cycle after the period ends; a late source only delays the period
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            adc_ready_o <= 1'b0;
        end
        else
        begin
            adc_ready_o <= (state == ST_IDLE) && (timer == '0) && !take;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    // [RULE_12] fixed step order
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            case (state)
                ST_IDLE:  state <= take ? ST_LOAD1 : ST_IDLE;
                ST_LOAD1: state <= ST_MUL1;
                // [RULE_07] idle step after multiply
                ST_MUL1:  state <= ST_WAIT1;
                ST_WAIT1: state <= ST_LOAD2;
                ST_LOAD2: state <= ST_MUL2;
                ST_MUL2:  state <= ST_WAIT2;
                ST_WAIT2: state <= ST_READ;
                ST_READ:  state <= ST_STORE;
                ST_STORE: state <= fifo_ready ? ST_IDLE : ST_STORE;
                default:  state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            sample <= 8'h00;
        end
        else if (take)
        begin
            sample <= adc_data_i;
        end
    end

    // ****************************************
    // multiply-accumulate unit
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            op <= '0;
        end
        else if (state == ST_LOAD1)
        begin
            // [RULE_04] [RULE_06] clear-and-multiply with k
            op <= '{cmd: `LPF_CMD_CLEAR_MUL, x: sample, z: `LPF_COEF_K};
        end
        else if (state == ST_LOAD2)
        begin
            // [RULE_05] [RULE_06] multiply-add with m
            op <= '{cmd: `LPF_CMD_MUL_ADD, x: prev_out, z: `LPF_COEF_M};
        end
    end

    // [RULE_02] second pass accumulates
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            acc <= 16'h0000;
        end
        else if ((state == ST_MUL1) || (state == ST_MUL2))
        begin
            acc <= mac_step(acc, op);
        end
    end

    // [RULE_01] upper byte is the new output
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            result <= 8'h00;
        end
        else if (state == ST_READ)
        begin
            result <= acc[15:8];
        end
    end

    // ****************************************
    // feedback cell and converter output
    // ****************************************
    // [RULE_03] [RULE_08] [RULE_11] delay cell, cleared at reset
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            prev_out <= `LPF_PREV_RESET;
        end
        else if (push)
        begin
            prev_out <= result;
        end
    end

    // [RULE_08] result to converter
    stream_fifo #(
        .WIDTH(`LPF_FIFO_WIDTH),
        .DEPTH(`LPF_FIFO_DEPTH)
    ) u_out_fifo (
        .clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(state == ST_STORE),
        .in_data_i(result),
        .in_ready_o(fifo_ready),
        .out_valid_o(dac_valid_o),
        .out_data_o(dac_data_o),
        .out_ready_i(dac_ready_i)
    );

    // ****************************************
    // checks
    // ****************************************
    sequence s_first_pass;
        state == ST_LOAD1 ##1 state == ST_MUL1 ##1 state == ST_WAIT1;
    endsequence

    sequence s_second_pass;
        state == ST_LOAD2 ##1 state == ST_MUL2 ##1 state == ST_WAIT2 ##1 state == ST_READ;
    endsequence

    a_pass_order: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_12]
        take |=> s_first_pass ##1 s_second_pass ##1 state == ST_STORE)
        else $error("processing steps out of order");

    a_first_cmd: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_04]
        state == ST_LOAD1 |=> op.cmd == 8'hF9 && op.z == 8'h33 && op.x == sample)
        else $error("first pass command or operands wrong");

    a_second_cmd: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_05]
        state == ST_LOAD2 |=> op.cmd == 8'hFD && op.z == 8'hCC && op.x == prev_out)
        else $error("second pass command or operands wrong");

    a_clear_pass: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_02]
        state == ST_MUL1 |=> acc == op.x * op.z)
        else $error("first pass did not clear accumulator");

    a_idle_step: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_07]
        (state == ST_MUL1 || state == ST_MUL2) |=> ##1 ($stable(acc) && $stable(op)))
        else $error("idle step after multiply disturbed");

    a_filter_eq: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_01]
        push |-> result == filter_ref(sample, prev_out))
        else $error("filter output does not match k*in + m*prev");

    a_store_prev: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_03]
        push |=> prev_out == $past(result))
        else $error("previous output not fed back");

    // the cell only moves when a result is stored; second pass reads it via a_second_cmd
    a_prev_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_03]
        !push |=> $stable(prev_out))
        else $error("delay cell changed without a stored result");

    a_sample_period: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_09]
        take |-> timer == 11'h000 ##1 timer == 11'h752)
        else $error("sample period wrong");

    a_reset_prev: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_11]
        $rose(resetn_i) |-> prev_out == 8'h00 && state == ST_IDLE)
        else $error("delay cell not cleared by reset");

endmodule : first_order_recursive_lowpass

// File: verilog/lpf_consts.svh
// Behaviour
// [RULE_01] Each sample period the output is k times the new input plus m times the previous output.
// [RULE_02] The work is two multiply passes, the second adding its product to what the first left.
// [RULE_03] The feedback delay is a storage cell written with each output and read back next period.
// [RULE_04] The first pass issues the command byte that clears the accumulator and then multiplies.
// [RULE_05] The second pass issues the command byte that multiplies and adds to the accumulator.
// [RULE_06] Coefficients k and m are constants loaded into the operand register before their pass.
// [RULE_07] One idle step follows each multiply command before operands are loaded or results read.
// [RULE_08] Each result goes to the converter output and is kept as the previous output.
// [RULE_09] The sample period is one processing loop, 75 microseconds in the reference timing. Here samples are 1876 clocks apart (75.04 us).
// [RULE_10] The input source must keep its signal below half the sampling rate, about 6.7 kHz.
// [RULE_11] All values are 8-bit unsigned fractions and the previous output is zero after reset.
// [RULE_12] Each period runs input, first pass, second pass, accumulator read, store and output in order.
`ifndef LPF_CONSTS_SVH
`define LPF_CONSTS_SVH

// ****************************************
// coefficients and command bytes
// ****************************************
`define LPF_COEF_K 8'h33
`define LPF_COEF_M 8'hCC
`define LPF_CMD_CLEAR_MUL 8'hF9
`define LPF_CMD_MUL_ADD 8'hFD
`define LPF_CMD_ACC_BIT 2
`define LPF_PREV_RESET 8'h00

// ****************************************
// timing
// ****************************************
`define LPF_CLK_NS 40
`define LPF_SAMPLE_NS 75000
`define LPF_SAMPLE_CYCLES (`LPF_SAMPLE_NS / `LPF_CLK_NS)

// ****************************************
// output buffer
// ****************************************
`define LPF_FIFO_WIDTH 8
`define LPF_FIFO_DEPTH 8

`endif

// File: verilog/lpf_pkg.sv
package lpf_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_LOAD1 = 4'h1,
        ST_MUL1  = 4'h2,
        ST_WAIT1 = 4'h3,
        ST_LOAD2 = 4'h4,
        ST_MUL2  = 4'h5,
        ST_WAIT2 = 4'h6,
        ST_READ  = 4'h7,
        ST_STORE = 4'h8
    } lpf_state_t;

    // one multiply-accumulate command with its operands
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] x;
        logic [7:0] z;
    } mac_op_t;

endpackage : lpf_pkg
